/* lrt_far_end.sv */
// Purpose: far side model, external timebase and control drivers
// Assumes: timebase made synchronous to mclk
// Notes: timebase parks high when off so no stray falling edge appears
`timescale 1ns/1ps
module lrt_far_end
	import lrt_pkg::*;
#(
	parameter int HALF = 3
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic trig,
	input wire logic clr,
	input wire logic mono,
	input wire logic div256_out,
	output logic ext_tbase,
	output lrt_ctl_t ctl
);
	int cnt;
	// full swing square wave with clean edges
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			ext_tbase <= 1'b1;
			cnt <= 0;
		end
		else if (!clk_en)
		begin
			ext_tbase <= 1'b1;
			cnt <= 0;
		end
		else if (cnt == HALF - 1)
		begin
			ext_tbase <= !ext_tbase;
			cnt <= 0;
		end
		else
			cnt <= cnt + 1;
	end
	assign ctl.trigger = trig;
	// one-shot wiring feeds divide-by-256 back to clear
	assign ctl.clear = mono ? div256_out : clr;
endmodule

/* lrt_pkg.sv */
// Purpose: shared constants and types for the long range timer counter
// Assumes: single clock domain, mclk at 10 MHz
// Notes: counter reset and start values fix the output levels
package lrt_pkg;
	localparam int LRT_CNT_W = 8;
	localparam logic [7:0] LRT_CNT_RESET = 8'hFF;
	localparam logic [7:0] LRT_CNT_START = 8'h00;
	localparam int LRT_HALF_EDGES = 128;
	localparam int LRT_MCLK_HZ = 10000000;
	localparam int LRT_MCLK_NS = 1000000000 / LRT_MCLK_HZ;
	// oscillator half period, no figure given, plain default
	localparam int LRT_OSC_HALF_NS = 500;
	localparam int LRT_OSC_HALF_CYC =
		(LRT_OSC_HALF_NS + LRT_MCLK_NS - 1) / LRT_MCLK_NS;
	localparam int LRT_OSC_W = 16;
	localparam logic [15:0] LRT_OSC_CNT_RESET = 16'h0000;
	localparam logic LRT_TBASE_RESET = 1'b1;

	typedef enum logic [1:0] {
		LRT_ST_IDLE = 2'b01,
		LRT_ST_RUN = 2'b10
	} lrt_state_t;

	typedef struct packed {
		logic trigger;
		logic clear;
	} lrt_ctl_t;
endpackage

/* lrt_timer.sv */
// Purpose: 8-bit timer counter with internal timebase and trigger control
// Assumes: all pin inputs synchronous to mclk
// Notes: timebase is sampled, so it must run well below mclk
//
// Function
// - reset state is entered at power up and when clear is high while trigger is low.
// - a rising trigger edge in the reset state starts counting and flips every stage.
// - at the start of a cycle both the divide-by-two and divide-by-256 outputs go low.
// - the divide-by-256 output returns high after 128 falling timebase edges.
// - a rising trigger edge starts the cycle even while clear is held high.
`timescale 1ns/1ps
module lrt_timer
	import lrt_pkg::*;
#(
	parameter int OSC_HALF = LRT_OSC_HALF_CYC
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire lrt_ctl_t ctl,
	input wire logic osc_timing_pin,
	input wire logic timebase_io_in,
	output logic timebase_io_out,
	output logic timebase_io_oe,
	output logic div2_out,
	output logic div256_out
);

	lrt_state_t state;
	lrt_state_t next_state;
	logic [LRT_CNT_W-1:0] cnt;
	logic [LRT_CNT_W-1:0] next_cnt;
	logic [LRT_CNT_W-1:0] cnt_adv;
	logic [LRT_CNT_W:0] carry;
	logic trig_q;
	logic next_trig_q;
	logic tbase_q;
	logic next_tbase_q;
	logic [LRT_OSC_W-1:0] osc_cnt;
	logic [LRT_OSC_W-1:0] next_osc_cnt;
	logic osc_lvl;
	logic next_osc_lvl;
	logic next_oe;
	logic tbase_now;
	logic tbase_fall;
	logic trig_rise;
	logic go_idle;
	logic start;
	logic osc_inhibit;

	// grounded timing pin stops the oscillator and frees the pin
	assign osc_inhibit = ~osc_timing_pin;
	assign tbase_now = osc_inhibit ? timebase_io_in : osc_lvl;
	assign tbase_fall = tbase_q & ~tbase_now;
	assign trig_rise = ctl.trigger & ~trig_q;
	// trigger high blocks clear, so a held trigger keeps the cycle alive
	assign go_idle = ctl.clear & ~ctl.trigger;
	assign start = (state == LRT_ST_IDLE) & trig_rise;

	// synchronous form of the ripple chain, avoids derived clocks
	assign carry[0] = tbase_fall;
	generate
		for (genvar i = 0; i < LRT_CNT_W; i++)
		begin : g_stage
			assign cnt_adv[i] = cnt[i] ^ carry[i];
			assign carry[i+1] = carry[i] & cnt[i];
		end
	endgenerate

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_trig_q = ctl.trigger;
		case (state)
			LRT_ST_IDLE:
			begin
				next_cnt = LRT_CNT_RESET;
				if (start)
				begin
					next_state = LRT_ST_RUN;
					next_cnt = ~LRT_CNT_RESET;
				end
			end
			LRT_ST_RUN:
			begin
				if (go_idle)
				begin
					next_state = LRT_ST_IDLE;
					next_cnt = LRT_CNT_RESET;
				end
				else
				begin
					next_cnt = cnt_adv;
				end
			end
			default:
			begin
				next_state = LRT_ST_IDLE;
				next_cnt = LRT_CNT_RESET;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state <= LRT_ST_IDLE;
			cnt <= LRT_CNT_RESET;
			trig_q <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			trig_q <= next_trig_q;
		end
	end

	assign div2_out = cnt[0];
	assign div256_out = cnt[LRT_CNT_W-1];

	// oscillator idles in reset to save power, restarts high at trigger
	always_comb
	begin
		next_osc_cnt = osc_cnt;
		next_osc_lvl = osc_lvl;
		next_tbase_q = tbase_now;
		next_oe = ~osc_inhibit;
		if (osc_inhibit || state == LRT_ST_IDLE || start)
		begin
			next_osc_cnt = LRT_OSC_CNT_RESET;
			next_osc_lvl = LRT_TBASE_RESET;
		end
		else if (osc_cnt == LRT_OSC_W'(OSC_HALF - 1))
		begin
			next_osc_cnt = LRT_OSC_CNT_RESET;
			next_osc_lvl = ~osc_lvl;
		end
		else
		begin
			next_osc_cnt = osc_cnt + 16'h0001;
		end
		if (start)
		begin
			next_tbase_q = LRT_TBASE_RESET;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			osc_cnt <= LRT_OSC_CNT_RESET;
			osc_lvl <= LRT_TBASE_RESET;
			tbase_q <= LRT_TBASE_RESET;
			timebase_io_oe <= 1'b0;
		end
		else
		begin
			osc_cnt <= next_osc_cnt;
			osc_lvl <= next_osc_lvl;
			tbase_q <= next_tbase_q;
			timebase_io_oe <= next_oe;
		end
	end

	assign timebase_io_out = osc_lvl;

	// helper: falling edges seen since the cycle began
	logic [8:0] fall_cnt;
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			fall_cnt <= 9'h000;
		end
		else if (start || state == LRT_ST_IDLE)
		begin
			fall_cnt <= 9'h000;
		end
		else if (tbase_fall && fall_cnt != 9'h1FF)
		begin
			fall_cnt <= fall_cnt + 9'h001;
		end
	end

	property p_enter_idle;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_RUN && go_idle) |=>
			(state == LRT_ST_IDLE && div2_out && div256_out);
	endproperty
	a_enter_idle: assert property (p_enter_idle)
		else $error("clear with trigger low did not reach reset state");

	property p_start;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_IDLE && trig_rise) |=>
			(state == LRT_ST_RUN && cnt == ~$past(cnt));
	endproperty
	a_start: assert property (p_start)
		else $error("trigger edge did not start and flip the chain");

	property p_outs_low;
		@(posedge mclk) disable iff (reset)
		start |=> (!div2_out && !div256_out) ##1
			(!div256_out || state == LRT_ST_IDLE);
	endproperty
	a_outs_low: assert property (p_outs_low)
		else $error("outputs not low at cycle start");

	property p_half_low;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_RUN && fall_cnt < 9'h080) |-> !div256_out;
	endproperty
	a_half_low: assert property (p_half_low)
		else $error("divide-by-256 output high before 128 edges");

	property p_half_high;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_RUN && fall_cnt == 9'h080) |-> div256_out;
	endproperty
	a_half_high: assert property (p_half_high)
		else $error("divide-by-256 output not high after 128 edges");

	property p_trig_wins;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_IDLE && ctl.clear && trig_rise) |=>
			state == LRT_ST_RUN;
	endproperty
	a_trig_wins: assert property (p_trig_wins)
		else $error("clear overrode trigger");

	property p_toggle;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_RUN && tbase_fall && !go_idle) |=>
			(div2_out != $past(div2_out));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("first stage missed a falling edge");

	property p_hold;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_RUN && !tbase_fall && !go_idle) |=> $stable(cnt);
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter moved without a falling edge");

	property p_wrap;
		@(posedge mclk) disable iff (reset)
		(state == LRT_ST_RUN && cnt == 8'hFF && tbase_fall && !go_idle) |=>
			(state == LRT_ST_RUN && cnt == 8'h00);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("free running counter did not wrap");

	property p_pin_free;
		@(posedge mclk) disable iff (reset)
		osc_inhibit |=> !timebase_io_oe;
	endproperty
	a_pin_free: assert property (p_pin_free)
		else $error("timebase pin driven while oscillator inhibited");

endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the long range timer counter
// Assumes: timebase half period of 3 mclk cycles, both sources
// Notes: falls are counted on the resolved timebase wire
`timescale 1ns/1ps
`define CHK(a, e) \
	begin \
		compares++; \
		if ((a) !== (e)) \
		begin \
			num_errors++; \
			$display("wrong value at %0t: got %h expected %h", \
				$time, a, e); \
		end \
	end
module tb_top
	import lrt_pkg::*;
;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic osc_pin = 1'b0;
	logic clk_en = 1'b0;
	logic trig = 1'b0;
	logic clr = 1'b0;
	logic mono = 1'b0;
	logic tbase_out;
	logic tbase_oe;
	logic div2_out;
	logic div256_out;
	logic ext_tbase;
	logic tbase_wire;
	lrt_ctl_t ctl;
	int num_errors = 0;
	int compares = 0;
	always #50 mclk = !mclk;
	// shared pin, the device wins while it drives
	assign tbase_wire = tbase_oe ? tbase_out : ext_tbase;
	lrt_timer #(.OSC_HALF(3)) u_lrt_timer (.mclk(mclk), .reset(reset),
		.ctl(ctl), .osc_timing_pin(osc_pin), .timebase_io_in(tbase_wire),
		.timebase_io_out(tbase_out), .timebase_io_oe(tbase_oe),
		.div2_out(div2_out), .div256_out(div256_out));
	lrt_far_end #(.HALF(3)) u_lrt_far_end (.mclk(mclk), .reset(reset),
		.clk_en(clk_en), .trig(trig), .clr(clr), .mono(mono),
		.div256_out(div256_out), .ext_tbase(ext_tbase), .ctl(ctl));
	task stop_test;
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// bounded wait; a hang here ends the run as a mismatch
	task wait_fall(input logic lvl, input int exp);
		int falls;
		logic prev;
		falls = 0;
		prev = tbase_wire;
		repeat (3000)
		begin
			@(posedge mclk);
			#1;
			if (prev && !tbase_wire)
				falls++;
			prev = tbase_wire;
			if (div256_out === lvl)
				break;
		end
		if (div256_out !== lvl)
		begin
			num_errors++;
			stop_test();
		end
		else
			`CHK(falls, exp)
	endtask
	task sc_start_run;
		@(posedge mclk);
		trig <= 1'b1;
		tick(2);
		`CHK(div2_out, 1'b0)
		`CHK(div256_out, 1'b0)
		@(posedge mclk);
		trig <= 1'b0;
		clk_en <= 1'b1;
		wait_fall(1'b1, 128);
		`CHK(div2_out, 1'b0)
		wait_fall(1'b0, 128);
	endtask
	task sc_clear_prio;
		@(posedge mclk);
		clk_en <= 1'b0;
		clr <= 1'b1;
		tick(2);
		`CHK({div2_out, div256_out}, 2'b11)
		@(posedge mclk);
		trig <= 1'b1;
		tick(2);
		`CHK(div256_out, 1'b0)
		@(posedge mclk);
		trig <= 1'b0;
		tick(2);
		`CHK(div256_out, 1'b1)
	endtask
	task sc_mono;
		@(posedge mclk);
		clr <= 1'b0;
		mono <= 1'b1;
		trig <= 1'b1;
		tick(2);
		`CHK(div256_out, 1'b0)
		@(posedge mclk);
		trig <= 1'b0;
		clk_en <= 1'b1;
		wait_fall(1'b1, 128);
		tick(3);
		`CHK({div2_out, div256_out}, 2'b11)
	endtask
	task sc_osc;
		@(posedge mclk);
		clk_en <= 1'b0;
		mono <= 1'b0;
		osc_pin <= 1'b1;
		tick(2);
		`CHK(tbase_oe, 1'b1)
		@(posedge mclk);
		trig <= 1'b1;
		tick(2);
		`CHK(div256_out, 1'b0)
		@(posedge mclk);
		trig <= 1'b0;
		wait_fall(1'b1, 128);
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		tick(1);
		`CHK({div2_out, div256_out, tbase_oe}, 3'b110)
		sc_start_run();
		sc_clear_prio();
		sc_mono();
		sc_osc();
		stop_test();
	end
endmodule
